// [bench/ptw_plc_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ptw_plc_model (
  input  wire logic          clk,   // System clock
  input  wire logic          ready, // Device can take a telegram
  output logic               stb,   // Telegram strobe
  output logic [1:0]         sel,   // Telegram type
  output logic [5:0][15:0]   w      // Mode, pos, one, two, main one, two
);
  logic [3:0] life; // Controller life count last sent
  initial begin
    stb = 1'b0;
    sel = 2'h0;
    w = '0;
    life = 4'h0;
  end
  // One telegram; ctl low or skip set break the controller's duties
  task automatic send(input logic [1:0] t, input logic [63:0] p,
                      input logic [15:0] m1, m2, input logic ctl, skip);
    while (!ready) @(negedge clk);
    life = life + (skip ? 4'h2 : 4'h1);
    sel = t;
    w = {life, m2[11:0], m1[15:11], ctl, m1[9:0], p};
    stb = 1'b1;
    @(posedge clk);
    @(negedge clk);
    stb = 1'b0;
    w = ~w; // Released lines must not keep the old value
  endtask
endmodule // ptw_plc_model
`default_nettype wire

// [bench/ptw_top_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module ptw_top_asserts (
  input wire logic        SYS_CLK, RESET_N, CYCLE_STROBE, CYCLE_READY,
  input wire logic [1:0]  TELEGRAM_SEL, DIRECTION_CODE,     // Codes
  input wire logic [15:0] POSITIONING_CONTROL_WORD_ONE,     // Word one
  input wire logic [15:0] MAIN_CONTROL_WORD_ONE,            // Main word
  input wire logic [15:0] DRIVE_STATUS_WORD_ONE, DRIVE_STATUS_WORD_TWO,
  input wire logic [5:0]  BLOCK_NUMBER,                     // Block field
  input wire logic        SPEED_NEGATIVE, COAST_DOWN_STOP_ACTIVE,
  input wire logic        DECODE_VALID, CONTROL_ACCEPTED, BLOCK_CHANGE,
  input wire logic        ABSOLUTE_POSITIONING, MANUAL_ENTRY_SELECTED,
  input wire logic        DIRECTION_POSITIVE, DIRECTION_NEGATIVE,
  input wire logic        STATUS_VALID                      // Status pulse
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire take = CYCLE_STROBE && CYCLE_READY;
  logic [3:0] last; // Life count of the previous status word
  logic       seen; // A status word went out since reset
  // Track the last life count so each send can be tied to the one before
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      last <= 4'h0;
      seen <= 1'b0;
    end else if (STATUS_VALID) begin
      last <= DRIVE_STATUS_WORD_TWO[15:12];
      seen <= 1'b1;
    end
  end
  // Fixed answer times and busy window of an exchange
  a_decode_then_status: assert property (take |=> !DECODE_VALID ##1
    DECODE_VALID ##1 (STATUS_VALID && !DECODE_VALID))
    else $error("decode or status pulse out of place");
  a_busy_window: assert property (take |=> !CYCLE_READY [*2] ##1 CYCLE_READY)
    else $error("ready not low for two cycles");
  a_abs_block_decode: assert property (take && &TELEGRAM_SEL &&
    MAIN_CONTROL_WORD_ONE[10] |-> ##2 ABSOLUTE_POSITIONING ==
    $past(POSITIONING_CONTROL_WORD_ONE[8], 2) && BLOCK_NUMBER ==
    $past(POSITIONING_CONTROL_WORD_ONE[5:0], 2))
    else $error("word one absolute or block field wrong");
  a_refused_hold: assert property (take && !MAIN_CONTROL_WORD_ONE[10]
    |-> ##2 !CONTROL_ACCEPTED && $stable(BLOCK_NUMBER) &&
    $stable(ABSOLUTE_POSITIONING)) else $error("refused telegram changed");
  a_dir_flags: assert property (DECODE_VALID |->
    DIRECTION_POSITIVE == (DIRECTION_CODE == 2'h1) &&
    DIRECTION_NEGATIVE == (DIRECTION_CODE == 2'h2))
    else $error("direction flags disagree with code");
  a_block_pulse: assert property (BLOCK_CHANGE |->
    DECODE_VALID && MANUAL_ENTRY_SELECTED) else $error("stray block change");
  a_life_steps: assert property (STATUS_VALID |->
    DRIVE_STATUS_WORD_TWO[15:12] == (seen ? last + 4'h1 : 4'h0))
    else $error("drive life count did not step by one");
  a_stop_rotation: assert property (STATUS_VALID |->
    DRIVE_STATUS_WORD_ONE[14] == !$past(SPEED_NEGATIVE) &&
    DRIVE_STATUS_WORD_ONE[4] == !$past(COAST_DOWN_STOP_ACTIVE))
    else $error("status one stop or rotation bit wrong");
  a_status_two_resv: assert property (STATUS_VALID |->
    (DRIVE_STATUS_WORD_TWO & 16'h0a9f) == 16'h0000)
    else $error("reserved status two bit set");
  c_block_change: cover property (BLOCK_CHANGE);
  c_refused: cover property (take && !MAIN_CONTROL_WORD_ONE[10]);
  c_life_wrap: cover property (STATUS_VALID && seen && last == 4'hf);
endmodule // ptw_top_asserts
bind ptw_top ptw_top_asserts i_ptw_top_asserts (.SYS_CLK, .RESET_N,
  .CYCLE_STROBE, .CYCLE_READY, .TELEGRAM_SEL, .DIRECTION_CODE,
  .POSITIONING_CONTROL_WORD_ONE, .MAIN_CONTROL_WORD_ONE,
  .DRIVE_STATUS_WORD_ONE, .DRIVE_STATUS_WORD_TWO, .BLOCK_NUMBER,
  .SPEED_NEGATIVE, .COAST_DOWN_STOP_ACTIVE, .DECODE_VALID, .CONTROL_ACCEPTED,
  .BLOCK_CHANGE, .ABSOLUTE_POSITIONING, .MANUAL_ENTRY_SELECTED,
  .DIRECTION_POSITIVE, .DIRECTION_NEGATIVE, .STATUS_VALID);
`default_nettype wire

// [bench/test_ptw_top.sv]
`timescale 1ns/1ns
`default_nettype none
module test_ptw_top;
  logic clk = 1'b0, rst_n, pm6, first;
  logic [19:0] cn;        // Drive conditions
  logic [20:0] ef;        // Decoded fields now expected
  logic [3:0]  dl, pl;    // Expected drive life, last controller life
  int          n_fail = 0, checks = 0;
  wire rdy, stb, sv;
  wire [1:0] sel;
  wire [5:0][15:0] w;
  wire [28:0] dq;
  wire [15:0] s1, s2;
  always #50 clk = ~clk;
  ptw_plc_model i_ptw_plc_model (.clk(clk), .ready(rdy), .stb(stb),
    .sel(sel), .w(w));
  ptw_top i_ptw_top (.SYS_CLK(clk), .RESET_N(rst_n), .CYCLE_STROBE(stb),
    .CYCLE_READY(rdy), .TELEGRAM_SEL(sel), .MANUAL_ENTRY_MODE_WORD(w[0]),
    .POSITIONING_CONTROL_WORD(w[1]), .POSITIONING_CONTROL_WORD_ONE(w[2]),
    .POSITIONING_CONTROL_WORD_TWO(w[3]), .MAIN_CONTROL_WORD_ONE(w[4]),
    .MAIN_CONTROL_WORD_TWO(w[5]), .READY_SERVO_ON(cn[0]),
    .READY_OPERATION(cn[1]), .OPERATION_ENABLED(cn[2]),
    .FAULT_PRESENT(cn[3]), .COAST_DOWN_STOP_ACTIVE(cn[4]),
    .FAST_STOP_ACTIVE(cn[5]), .SWITCH_ON_INHIBITED(cn[6]),
    .ALARM_PRESENT(cn[7]), .SPEED_IN_TOLERANCE(cn[8]),
    .CONTROL_REQUEST(cn[9]), .COMPARE_REACHED(cn[10]),
    .LIMIT_REACHED(cn[11]), .BRAKE_OPEN(cn[12]),
    .MOTOR_OVERTEMP_ALARM(cn[13]), .SPEED_NEGATIVE(cn[14]),
    .POWER_UNIT_OVERLOAD(cn[15]), .ALARM_CLASS(cn[17:16]),
    .FIXED_ENDSTOP(cn[18]), .PULSES_ENABLED(cn[19]),
    .DECODE_VALID(dq[28]), .BLOCK_CHANGE(dq[27]),
    .MASTER_LIFE_ERROR(dq[26]), .MASTER_LIFE(dq[25:22]),
    .CONTROL_ACCEPTED(dq[21]), .ABSOLUTE_POSITIONING(dq[20]),
    .DIRECTION_CODE(dq[19:18]), .DIRECTION_POSITIVE(dq[17]),
    .DIRECTION_NEGATIVE(dq[16]), .TRACKING_MODE(dq[15]),
    .SET_REFERENCE(dq[14]), .REFERENCE_CAM(dq[13]),
    .JOG_INCREMENTAL(dq[12]), .BLOCK_NUMBER(dq[11:6]),
    .CONTINUOUS_TRANSFER(dq[5]), .SETUP_SELECTED(dq[4]),
    .MANUAL_ENTRY_SELECTED(dq[3]), .REF_SEARCH_NEGATIVE(dq[2]),
    .SOFT_LIMIT_ENABLE(dq[1]), .STOP_CAM_ENABLE(dq[0]),
    .DRIVE_STATUS_WORD_ONE(s1), .DRIVE_STATUS_WORD_TWO(s2),
    .STATUS_VALID(sv));
  // Fields a telegram should leave; p is {two, one, pos, mode}
  function automatic logic [20:0] fields(input logic [1:0] t,
                                         input logic [63:0] p);
    logic [1:0]  d;
    logic [15:0] a, b;
    d = t == 2'h1 ? p[2:1] : t == 2'h3 ? p[42:41] : 2'h0;
    a = t == 2'h3 ? p[47:32] : 16'h0000;
    b = t == 2'h3 ? p[63:48] : t == 2'h2 ? p[31:16] : 16'h0000;
    return {t == 2'h1 ? p[0] : a[8], d, d == 2'h1, d == 2'h2, b[0], b[1],
      b[2], b[5], a[5:0], a[12], a[14], a[15], b[9] & t[0], b[14] & t[0],
      b[15] & t[0]};
  endfunction
  // Both status words; stop and thermal bits read inverted
  function automatic logic [31:0] stat(input logic [19:0] c,
                                       input logic [3:0] l);
    return {l, 1'b0, c[19], 1'b0, c[18], 1'b0, c[17:16], 5'h00,
      c[15:0] ^ 16'he030};
  endfunction
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One exchange at the closest spacing the sequencer allows
  task automatic one(input logic [1:0] t, input logic skip);
    logic [63:0] p;
    logic [15:0] m1;
    logic        ctl, bc;
    p = {$urandom, $urandom};
    m1 = 16'($urandom);
    ctl = t == 2'h3 || $urandom_range(3) != 0;
    bc = ctl && t == 2'h3 && p[47] && (p[44] || (m1[6] && !pm6));
    cn = 20'($urandom);
    i_ptw_plc_model.send(t, p, m1, 16'($urandom), ctl, skip);
    if (ctl) ef = fields(t, p);
    pm6 = m1[6];
    @(negedge clk);
    cmp(dq, {1'b1, bc, !first && i_ptw_plc_model.life != pl + 4'h1,
      i_ptw_plc_model.life, ctl, ef});
    @(negedge clk);
    cmp({sv, s2, s1}, {1'b1, stat(cn, dl)});
    dl = dl + 4'h1;
    pl = i_ptw_plc_model.life;
    first = 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 930 cycles
  initial begin
    #500000;
    n_fail++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    cn = '0;
    {pm6, first, ef, dl, pl} = {2'b01, 29'h0};
    void'($urandom(32'hffd15f45));
    repeat (16) @(negedge clk);
    cmp({rdy, dq, s2, s1}, {1'b1, 61'h0});
    rst_n = 1'b1;
    for (int t = 0; t < 4; t++) one(2'(t), 1'b0);
    one(2'h3, 1'b1);
    $display("test corner done");
    repeat (300) one(2'($urandom_range(3)), $urandom_range(15) == 0);
    $display("test random done");
    stop_test();
  end
endmodule // test_ptw_top
`default_nettype wire

// [src/ptw_pkg.sv]
`default_nettype none
package ptw_pkg;

  // Word and field widths
  localparam int WORD_W  = 16;
  localparam int LIFE_W  = 4;
  localparam int BLOCK_W = 6;

  // Telegram that the controller has configured
  typedef enum logic [1:0] {
    PTW_TEL_SPEED = 2'h0,    // Telegrams 1, 2, 3 and 5
    PTW_TEL_9     = 2'h1,
    PTW_TEL_110   = 2'h2,
    PTW_TEL_111   = 2'h3
  } ptw_tel_t;

  // Exchange sequencer, one-hot
  typedef enum logic [2:0] {
    PTW_ST_IDLE   = 3'h1,
    PTW_ST_DECODE = 3'h2,
    PTW_ST_SEND   = 3'h4
  } ptw_state_t;

  // Direction codes of absolute and manual-entry moves
  localparam logic [1:0] DIR_SHORT  = 2'h0;
  localparam logic [1:0] DIR_PLUS   = 2'h1;
  localparam logic [1:0] DIR_MINUS  = 2'h2;
  localparam logic [1:0] DIR_SHORT2 = 2'h3;

  // Manual-entry mode word fields
  localparam int MODE_ABS     = 0;
  localparam int MODE_DIR_LSB = 1;
  // Positioning control word (and word two) common fields
  localparam int PC_TRACK   = 0;
  localparam int PC_SETREF  = 1;
  localparam int PC_REFCAM  = 2;
  localparam int PC_JOG_INC = 5;
  // Positioning control word one fields
  localparam int P1_BLK_LSB = 0;
  localparam int P1_ABS     = 8;
  localparam int P1_DIR_LSB = 9;
  localparam int P1_CONT    = 12;
  localparam int P1_SETUP   = 14;
  localparam int P1_MANUAL  = 15;
  // Positioning control word two fields
  localparam int P2_REF_NEG = 9;
  localparam int P2_SWLIM   = 14;
  localparam int P2_STOPCAM = 15;
  // Main control word fields that this block reads
  localparam int M1_SETPOINT = 6;
  localparam int M1_PLC      = 10;
  localparam int M2_LIFE_LSB = 12;
  // Status word two fields
  localparam int S2_ALARM_LSB = 5;
  localparam int S2_ENDSTOP   = 8;
  localparam int S2_PULSES    = 10;
  localparam int S2_LIFE_LSB  = 12;

  // Masks of defined bits; everything else is reserved and dropped
  localparam logic [15:0] MODE_MASK = 16'h0007;
  localparam logic [15:0] PC_MASK   = 16'h0027;
  localparam logic [15:0] P1_MASK   = 16'hd73f;
  localparam logic [15:0] P2_MASK   = 16'hc227;
  localparam logic [15:0] M1_MASK   = 16'h0440;
  localparam logic [15:0] M2_MASK   = 16'hf000;

  // Values after reset
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0]  LIFE_RST = 4'h0;

  // Drive conditions reported in the status words
  typedef struct packed {
    logic       ready_servo_on;
    logic       ready_operation;
    logic       operation_enabled;
    logic       fault;
    logic       coast_stop_active;
    logic       fast_stop_active;
    logic       switch_on_inhibited;
    logic       alarm;
    logic       speed_in_tol;
    logic       control_request;
    logic       compare_reached;
    logic       limit_reached;
    logic       brake_open;
    logic       motor_overtemp;
    logic       speed_negative;
    logic       power_overload;
    logic [1:0] alarm_class;
    logic       fixed_endstop;
    logic       pulses_enabled;
  } ptw_cond_t;

endpackage
`default_nettype wire

// [src/ptw_status_enc.sv]
`timescale 1ns/1ns
`default_nettype none
module ptw_status_enc #(
  parameter int LIFE_W = ptw_pkg::LIFE_W
) (
  input  wire logic              clk,        // System clock
  input  wire logic              rst_n,      // Synchronous reset, low
  input  wire logic              send,       // One-cycle send request
  input  wire ptw_pkg::ptw_cond_t cond,      // Drive conditions
  output logic [15:0]            status_one, // Status word one
  output logic [15:0]            status_two, // Status word two
  output logic                   tx_valid    // Words updated, pulse
);

  // The life counter occupies a fixed four-bit field
  if (LIFE_W != 4) begin : g_bad_life
    $error("ptw_status_enc: LIFE_W must be 4");
  end

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [3:0]  life;
    logic        valid;
  } ptw_enc_state_t;

  ptw_enc_state_t r;
  ptw_enc_state_t next_r;

  // Words are frozen at send time so one telegram is self-consistent
  always_comb begin
    next_r       = r;
    next_r.valid = 1'b0;
    if (send) begin
      next_r.s1 = {
        ~cond.power_overload,
        ~cond.speed_negative,
        ~cond.motor_overtemp,
        cond.brake_open,
        cond.limit_reached,
        cond.compare_reached,
        cond.control_request,
        cond.speed_in_tol,
        cond.alarm,
        cond.switch_on_inhibited,
        ~cond.fast_stop_active,
        ~cond.coast_stop_active,
        cond.fault,
        cond.operation_enabled,
        cond.ready_operation,
        cond.ready_servo_on
      };
      // Reserved positions stay zero
      next_r.s2 = ptw_pkg::WORD_RST;
      next_r.s2[ptw_pkg::S2_ALARM_LSB +: 2] = cond.alarm_class;
      next_r.s2[ptw_pkg::S2_ENDSTOP] = cond.fixed_endstop;
      next_r.s2[ptw_pkg::S2_PULSES]  = cond.pulses_enabled;
      next_r.s2[ptw_pkg::S2_LIFE_LSB +: 4] = r.life;
      // Wraps modulo 16 so the controller sees a moving count
      next_r.life  = r.life + 4'h1;
      next_r.valid = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign status_one = r.s1;
  assign status_two = r.s2;
  assign tx_valid   = r.valid;

endmodule // ptw_status_enc
`default_nettype wire

// [src/ptw_top.sv]
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Mode bit 0 or word-one bit 8: one absolute, zero relative.
// - Mode bits 1-2 direction: 0/3 shortest, 1 positive, 2 negative.
// - Bit 0 of positioning words switches tracking mode on.
// - Bit 1 of positioning words requests setting the reference point.
// - Bit 2 reference cam active; bit 5 incremental else velocity jog.
// - Word-one bits 0-5 carry the traversing block number, LSB at 0.
// - Word-one bits 9-10 direction: 0/3 shortest, 1 plus, 2 minus.
// - Word-one bit 12 continuous transfer, else change on setpoint edge; block changes only with bit 15 set.
// - Word-one bit 14 setting-up else positioning; bit 15 manual entry.
// - Word-two bit 9 starts reference search negative, else positive.
// - Word-two bit 14 enables soft limits; bit 15 enables stop cam.
// - Status one bits 0-2 report the readiness chain, active high.
// - Status one bits 3, 6, 7: fault, switch-on inhibit, alarm.
// - Status one bits 4, 5 set when no coast or fast stop.
// - Status one bit 8 speed in tolerance, bit 10 comparison reached.
// - Status one bit 9 tells the controller control is requested.
// - Status one bit 11 limit reached, bit 12 open holding brake.
// - Status one bits 13, 15 high while no thermal alarms.
// - Status one bit 14 high for zero or positive speed.
// - Status two bits 5-6 carry the alarm class, LSB at 5.
// - Status two bit 8 fixed endstop travel, bit 10 pulses enabled.
// - Status two bits 12-15 return the drive life counter.
module ptw_top (
  input  wire logic        SYS_CLK,                // 10 MHz clock
  input  wire logic        RESET_N,                // Sync reset, low
  input  wire logic        CYCLE_STROBE,           // Telegram received
  output logic             CYCLE_READY,            // Strobe can be taken
  input  wire logic [1:0]  TELEGRAM_SEL,           // Configured telegram
  input  wire logic [15:0] MANUAL_ENTRY_MODE_WORD, // Telegram 9
  input  wire logic [15:0] POSITIONING_CONTROL_WORD,     // Telegram 110
  input  wire logic [15:0] POSITIONING_CONTROL_WORD_ONE, // Telegram 111
  input  wire logic [15:0] POSITIONING_CONTROL_WORD_TWO, // Telegram 111
  input  wire logic [15:0] MAIN_CONTROL_WORD_ONE,  // Main control word 1
  input  wire logic [15:0] MAIN_CONTROL_WORD_TWO,  // Main control word 2
  input  wire logic        READY_SERVO_ON,         // Ready for servo on
  input  wire logic        READY_OPERATION,        // Ready for operation
  input  wire logic        OPERATION_ENABLED,      // Operation enabled
  input  wire logic        FAULT_PRESENT,          // Fault present
  input  wire logic        COAST_DOWN_STOP_ACTIVE, // Coast-down stop on
  input  wire logic        FAST_STOP_ACTIVE,       // Fast stop on
  input  wire logic        SWITCH_ON_INHIBITED,    // Switch-on inhibit
  input  wire logic        ALARM_PRESENT,          // Alarm present
  input  wire logic        SPEED_IN_TOLERANCE,     // Deviation in band
  input  wire logic        CONTROL_REQUEST,        // Drive asks control
  input  wire logic        COMPARE_REACHED,        // f or n reached
  input  wire logic        LIMIT_REACHED,          // I, M or P limit
  input  wire logic        BRAKE_OPEN,             // Open holding brake
  input  wire logic        MOTOR_OVERTEMP_ALARM,   // Motor too hot
  input  wire logic        SPEED_NEGATIVE,         // Actual speed < 0
  input  wire logic        POWER_UNIT_OVERLOAD,    // Power unit too hot
  input  wire logic [1:0]  ALARM_CLASS,            // Alarm class
  input  wire logic        FIXED_ENDSTOP,          // Going to endstop
  input  wire logic        PULSES_ENABLED,         // Power pulses on
  output logic             DECODE_VALID,           // Fields updated
  output logic             CONTROL_ACCEPTED,       // Controller in charge
  output logic             ABSOLUTE_POSITIONING,   // Absolute, not rel.
  output logic [1:0]       DIRECTION_CODE,         // Raw direction code
  output logic             DIRECTION_POSITIVE,     // Positive direction
  output logic             DIRECTION_NEGATIVE,     // Negative direction
  output logic             TRACKING_MODE,          // Tracking mode on
  output logic             SET_REFERENCE,          // Set reference point
  output logic             REFERENCE_CAM,          // Reference cam active
  output logic             JOG_INCREMENTAL,        // Incremental jogging
  output logic [5:0]       BLOCK_NUMBER,           // Traversing block
  output logic             CONTINUOUS_TRANSFER,    // Continuous setpoints
  output logic             BLOCK_CHANGE,           // Take new block, pulse
  output logic             SETUP_SELECTED,         // Setting-up operation
  output logic             MANUAL_ENTRY_SELECTED,  // Manual-entry mode
  output logic             REF_SEARCH_NEGATIVE,    // Search toward minus
  output logic             SOFT_LIMIT_ENABLE,      // Soft limits active
  output logic             STOP_CAM_ENABLE,        // Stop cam active
  output logic [3:0]       MASTER_LIFE,            // Controller count
  output logic             MASTER_LIFE_ERROR,      // Count did not step
  output logic [15:0]      DRIVE_STATUS_WORD_ONE,  // Status word one
  output logic [15:0]      DRIVE_STATUS_WORD_TWO,  // Status word two
  output logic             STATUS_VALID            // Words updated, pulse
);

  // Decoded command fields, rebuilt on every accepted telegram
  typedef struct packed {
    logic       abs_pos;
    logic [1:0] dir_code;
    logic       dir_plus;
    logic       dir_minus;
    logic       track;
    logic       set_ref;
    logic       ref_cam;
    logic       jog_inc;
    logic [5:0] block_num;
    logic       cont_xfer;
    logic       setup_sel;
    logic       manual_sel;
    logic       ref_neg;
    logic       sw_limit;
    logic       stop_cam;
  } ptw_dec_t;

  typedef struct packed {
    ptw_pkg::ptw_state_t state;
    ptw_pkg::ptw_tel_t   tel;
    logic [15:0]         mode_w;
    logic [15:0]         pc_w;
    logic [15:0]         p1_w;
    logic [15:0]         p2_w;
    logic [15:0]         m1_w;
    logic [15:0]         m2_w;
    logic                setpoint_prev;
    logic                life_seen;
    logic [3:0]          master_life;
    logic                life_error;
    logic                accepted;
    logic                block_change;
    logic                send;
    ptw_dec_t            dec;
  } ptw_top_state_t;

  ptw_top_state_t     r;
  ptw_top_state_t     next_r;
  ptw_pkg::ptw_cond_t cond;

  // Translate a direction code into plus and minus levels
  function automatic logic [1:0] ptw_dir_levels(input logic [1:0] code);
    logic [1:0] lv;
    lv = 2'h0;
    case (code)
      ptw_pkg::DIR_PLUS:   lv = 2'h1;
      ptw_pkg::DIR_MINUS:  lv = 2'h2;
      // Codes 0 and 3 both mean the shortest path
      ptw_pkg::DIR_SHORT:  lv = 2'h0;
      ptw_pkg::DIR_SHORT2: lv = 2'h0;
      default:             lv = 2'h0;
    endcase
    return lv;
  endfunction

  // Exchange sequencer and command decode
  always_comb begin
    next_r              = r;
    next_r.block_change = 1'b0;
    next_r.send         = 1'b0;
    case (r.state)
      ptw_pkg::PTW_ST_IDLE: begin
        if (CYCLE_STROBE) begin
          // Reserved bits are masked off on capture
          next_r.tel    = ptw_pkg::ptw_tel_t'(TELEGRAM_SEL);
          next_r.mode_w = MANUAL_ENTRY_MODE_WORD
                          & ptw_pkg::MODE_MASK;
          next_r.pc_w   = POSITIONING_CONTROL_WORD
                          & ptw_pkg::PC_MASK;
          next_r.p1_w   = POSITIONING_CONTROL_WORD_ONE
                          & ptw_pkg::P1_MASK;
          next_r.p2_w   = POSITIONING_CONTROL_WORD_TWO
                          & ptw_pkg::P2_MASK;
          next_r.m1_w   = MAIN_CONTROL_WORD_ONE & ptw_pkg::M1_MASK;
          next_r.m2_w   = MAIN_CONTROL_WORD_TWO & ptw_pkg::M2_MASK;
          next_r.state  = ptw_pkg::PTW_ST_DECODE;
        end
      end
      ptw_pkg::PTW_ST_DECODE: begin
        // Life count must step by one; the first telegram only seeds it
        next_r.life_error = r.life_seen &&
          (r.m2_w[ptw_pkg::M2_LIFE_LSB +: 4]
           != (r.master_life + 4'h1));
        next_r.master_life = r.m2_w[ptw_pkg::M2_LIFE_LSB +: 4];
        next_r.life_seen   = 1'b1;
        // Commands count only while the controller holds control
        next_r.accepted = r.m1_w[ptw_pkg::M1_PLC];
        next_r.setpoint_prev = r.m1_w[ptw_pkg::M1_SETPOINT];
        if (r.m1_w[ptw_pkg::M1_PLC]) begin
          // Fields of the telegram not in use read as zero
          next_r.dec = '0;
          case (r.tel)
            ptw_pkg::PTW_TEL_9: begin
              next_r.dec.abs_pos  = r.mode_w[ptw_pkg::MODE_ABS];
              next_r.dec.dir_code =
                r.mode_w[ptw_pkg::MODE_DIR_LSB +: 2];
            end
            ptw_pkg::PTW_TEL_110: begin
              next_r.dec.track   = r.pc_w[ptw_pkg::PC_TRACK];
              next_r.dec.set_ref = r.pc_w[ptw_pkg::PC_SETREF];
              next_r.dec.ref_cam = r.pc_w[ptw_pkg::PC_REFCAM];
              next_r.dec.jog_inc = r.pc_w[ptw_pkg::PC_JOG_INC];
            end
            ptw_pkg::PTW_TEL_111: begin
              next_r.dec.block_num =
                r.p1_w[ptw_pkg::P1_BLK_LSB +: ptw_pkg::BLOCK_W];
              next_r.dec.abs_pos  = r.p1_w[ptw_pkg::P1_ABS];
              next_r.dec.dir_code =
                r.p1_w[ptw_pkg::P1_DIR_LSB +: 2];
              next_r.dec.cont_xfer  = r.p1_w[ptw_pkg::P1_CONT];
              next_r.dec.setup_sel  = r.p1_w[ptw_pkg::P1_SETUP];
              next_r.dec.manual_sel = r.p1_w[ptw_pkg::P1_MANUAL];
              next_r.dec.track   = r.p2_w[ptw_pkg::PC_TRACK];
              next_r.dec.set_ref = r.p2_w[ptw_pkg::PC_SETREF];
              next_r.dec.ref_cam = r.p2_w[ptw_pkg::PC_REFCAM];
              next_r.dec.jog_inc = r.p2_w[ptw_pkg::PC_JOG_INC];
              next_r.dec.ref_neg  = r.p2_w[ptw_pkg::P2_REF_NEG];
              next_r.dec.sw_limit = r.p2_w[ptw_pkg::P2_SWLIM];
              next_r.dec.stop_cam = r.p2_w[ptw_pkg::P2_STOPCAM];
              // In manual entry, continuous mode takes every telegram; otherwise only
              // a rising setpoint-enable edge may switch the block
              if (r.p1_w[ptw_pkg::P1_MANUAL]) begin
                next_r.block_change = r.p1_w[ptw_pkg::P1_CONT] ||
                  (r.m1_w[ptw_pkg::M1_SETPOINT] &&
                   !r.setpoint_prev);
              end
            end
            default: begin
              // Speed telegrams carry no positioning commands
              next_r.dec = '0;
            end
          endcase
          {next_r.dec.dir_minus, next_r.dec.dir_plus} =
            ptw_dir_levels(next_r.dec.dir_code);
        end
        next_r.send  = 1'b1;
        next_r.state = ptw_pkg::PTW_ST_SEND;
      end
      ptw_pkg::PTW_ST_SEND: begin
        // Status words are built by the encoder in this cycle
        next_r.state = ptw_pkg::PTW_ST_IDLE;
      end
      default: begin
        next_r.state = ptw_pkg::PTW_ST_IDLE;
      end
    endcase
  end

  // State register; the sequencer restarts idle
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      r       <= '0;
      r.state <= ptw_pkg::PTW_ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Drive conditions gathered for the encoder
  assign cond.ready_servo_on      = READY_SERVO_ON;
  assign cond.ready_operation     = READY_OPERATION;
  assign cond.operation_enabled   = OPERATION_ENABLED;
  assign cond.fault               = FAULT_PRESENT;
  assign cond.coast_stop_active   = COAST_DOWN_STOP_ACTIVE;
  assign cond.fast_stop_active    = FAST_STOP_ACTIVE;
  assign cond.switch_on_inhibited = SWITCH_ON_INHIBITED;
  assign cond.alarm               = ALARM_PRESENT;
  assign cond.speed_in_tol        = SPEED_IN_TOLERANCE;
  assign cond.control_request     = CONTROL_REQUEST;
  assign cond.compare_reached     = COMPARE_REACHED;
  assign cond.limit_reached       = LIMIT_REACHED;
  assign cond.brake_open          = BRAKE_OPEN;
  assign cond.motor_overtemp      = MOTOR_OVERTEMP_ALARM;
  assign cond.speed_negative      = SPEED_NEGATIVE;
  assign cond.power_overload      = POWER_UNIT_OVERLOAD;
  assign cond.alarm_class         = ALARM_CLASS;
  assign cond.fixed_endstop       = FIXED_ENDSTOP;
  assign cond.pulses_enabled      = PULSES_ENABLED;

  // Status words and the drive life counter
  ptw_status_enc #(
    .LIFE_W (ptw_pkg::LIFE_W)
  ) u_enc (
    .clk        (SYS_CLK),
    .rst_n      (RESET_N),
    .send       (r.send),
    .cond       (cond),
    .status_one (DRIVE_STATUS_WORD_ONE),
    .status_two (DRIVE_STATUS_WORD_TWO),
    .tx_valid   (STATUS_VALID)
  );

  // Handshake is combinational; a strobe while busy is dropped
  assign CYCLE_READY = (r.state == ptw_pkg::PTW_ST_IDLE);

  // Decoded outputs straight from flip-flops
  assign DECODE_VALID          = r.send;
  assign CONTROL_ACCEPTED      = r.accepted;
  assign ABSOLUTE_POSITIONING  = r.dec.abs_pos;
  assign DIRECTION_CODE        = r.dec.dir_code;
  assign DIRECTION_POSITIVE    = r.dec.dir_plus;
  assign DIRECTION_NEGATIVE    = r.dec.dir_minus;
  assign TRACKING_MODE         = r.dec.track;
  assign SET_REFERENCE         = r.dec.set_ref;
  assign REFERENCE_CAM         = r.dec.ref_cam;
  assign JOG_INCREMENTAL       = r.dec.jog_inc;
  assign BLOCK_NUMBER          = r.dec.block_num;
  assign CONTINUOUS_TRANSFER   = r.dec.cont_xfer;
  assign BLOCK_CHANGE          = r.block_change;
  assign SETUP_SELECTED        = r.dec.setup_sel;
  assign MANUAL_ENTRY_SELECTED = r.dec.manual_sel;
  assign REF_SEARCH_NEGATIVE   = r.dec.ref_neg;
  assign SOFT_LIMIT_ENABLE     = r.dec.sw_limit;
  assign STOP_CAM_ENABLE       = r.dec.stop_cam;
  assign MASTER_LIFE           = r.master_life;
  assign MASTER_LIFE_ERROR     = r.life_error;

endmodule // ptw_top
`default_nettype wire
